// ==== rtl/eips_defs.vh ====
// Contract
// R1 - Each 3-bit selector codes 0..5 as ports A..F for its line.
// R2 - Line n always takes pin n of the chosen port; selector picks port only.
// R3 - Line 0 selector at low register bits 2:0, read-write, resets to zero.
// R4 - Lines 1..3 at bits 6:4, 10:8, 14:12; bit above each is reserved.
// R5 - Software writes zero into every reserved bit of both registers.
// R6 - High register at 0x104 holds lines 8..15, four-bit stride, reset zero.
// R7 - Codes six and seven choose no port; line sees constant inactive input.
`ifndef EIPS_DEFS_VH
`define EIPS_DEFS_VH

// ********************************************************************
// Register map
// ********************************************************************
`define EIPS_LOW_OFFSET 12'h100
`define EIPS_HIGH_OFFSET 12'h104
`define EIPS_ADDR_W 12
`define EIPS_RESET_VALUE 32'h0000_0000
// Selector fields sit on a four-bit stride, three bits wide
`define EIPS_FIELD_STRIDE 4
`define EIPS_FIELD_W 3
// Writable bits: low three bits of every nibble
`define EIPS_WRITE_MASK 32'h7777_7777

// ********************************************************************
// Selector encodings
// ********************************************************************
`define EIPS_BANK_A_CHOICE 3'h0
`define EIPS_BANK_B_CHOICE 3'h1
`define EIPS_BANK_C_CHOICE 3'h2
`define EIPS_BANK_D_CHOICE 3'h3
`define EIPS_BANK_E_CHOICE 3'h4
`define EIPS_BANK_F_CHOICE 3'h5

`endif

// ==== rtl/eips_line_mux.v ====
`include "eips_defs.vh"
`default_nettype none

// ********************************************************************
// One line's port picker
// ********************************************************************
module eips_line_mux (
  input wire [2:0] source_port,
  input wire [5:0] bank_pins,
  output reg line_out
);

  // Unused codes give a quiet line rather than an aliased port
  always @* begin
    case (source_port)
      // R1 code to port
      `EIPS_BANK_A_CHOICE: line_out = bank_pins[0];
      `EIPS_BANK_B_CHOICE: line_out = bank_pins[1];
      `EIPS_BANK_C_CHOICE: line_out = bank_pins[2];
      `EIPS_BANK_D_CHOICE: line_out = bank_pins[3];
      `EIPS_BANK_E_CHOICE: line_out = bank_pins[4];
      `EIPS_BANK_F_CHOICE: line_out = bank_pins[5];
      // R7 no port chosen
      default: line_out = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

// ==== rtl/eips_top.v ====
`include "eips_defs.vh"
`default_nettype none

// ********************************************************************
// External interrupt port select
// ********************************************************************
module eips_top (
  input wire clk,
  input wire resetn,
  input wire [11:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [31:0] reg_rdata,
  input wire [15:0] bank_a_pins,
  input wire [15:0] bank_b_pins,
  input wire [15:0] bank_c_pins,
  input wire [15:0] bank_d_pins,
  input wire [15:0] bank_e_pins,
  input wire [15:0] bank_f_pins,
  output reg [15:0] ext_irq_lines
);

  reg [31:0] ext_irq_port_select_low_reg;
  reg [31:0] ext_irq_port_select_high_reg;
  reg [31:0] ext_irq_port_select_low_next;
  reg [31:0] ext_irq_port_select_high_next;
  reg [31:0] reg_rdata_next;
  reg [95:0] pins_meta_reg;
  reg [95:0] pins_sync_reg;
  wire low_hit;
  wire high_hit;
  wire [15:0] bank_a_sync;
  wire [15:0] bank_b_sync;
  wire [15:0] bank_c_sync;
  wire [15:0] bank_d_sync;
  wire [15:0] bank_e_sync;
  wire [15:0] bank_f_sync;
  wire [2:0] line0_source_port;
  wire [2:0] line1_source_port;
  wire [2:0] line2_source_port;
  wire [2:0] line3_source_port;
  wire [2:0] line4_source_port;
  wire [2:0] line5_source_port;
  wire [2:0] line6_source_port;
  wire [2:0] line7_source_port;
  wire [2:0] line8_source_port;
  wire [2:0] line9_source_port;
  wire [2:0] line10_source_port;
  wire [2:0] line11_source_port;
  wire [2:0] line12_source_port;
  wire [2:0] line13_source_port;
  wire [2:0] line14_source_port;
  wire [2:0] line15_source_port;
  wire [47:0] line_ports;
  wire [15:0] line_next;

  // Picks one line's 3-bit selector from the register pair
  function [2:0] line_source_port;
    input [31:0] low_word;
    input [31:0] high_word;
    input [3:0] line;
    reg [31:0] word;
    begin
      word = line[3] ? high_word : low_word;
      line_source_port = word[line[2:0]*`EIPS_FIELD_STRIDE +: `EIPS_FIELD_W];
    end
  endfunction

  // True when the bus address names the given register
  function addr_hits;
    input [11:0] addr;
    input [11:0] offset;
    begin
      addr_hits = (addr == offset);
    end
  endfunction

  // Clears reserved bits so they can never read back as one
  function [31:0] writable_bits;
    input [31:0] data;
    begin
      writable_bits = data & `EIPS_WRITE_MASK;
    end
  endfunction

  // ******************************************************************
  // Address decode
  // ******************************************************************
  // Only the exact word offsets hit; anything else is ignored
  assign low_hit = addr_hits(reg_addr, `EIPS_LOW_OFFSET);
  assign high_hit = addr_hits(reg_addr, `EIPS_HIGH_OFFSET);

  // ******************************************************************
  // Register writes
  // ******************************************************************
  // Hold unless the matching offset is written
  always @* begin
    ext_irq_port_select_low_next = ext_irq_port_select_low_reg;
    ext_irq_port_select_high_next = ext_irq_port_select_high_reg;
    // R4 reserved bits dropped
    if (reg_write && low_hit) begin
      ext_irq_port_select_low_next = writable_bits(reg_wdata);
    end
    // R6 high register write
    if (reg_write && high_hit) begin
      ext_irq_port_select_high_next = writable_bits(reg_wdata);
    end
  end

  // Reset leaves every line on port A
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // R3 reset port A
      ext_irq_port_select_low_reg <= `EIPS_RESET_VALUE;
      // R6 high reset zero
      ext_irq_port_select_high_reg <= `EIPS_RESET_VALUE;
    end else begin
      ext_irq_port_select_low_reg <= ext_irq_port_select_low_next;
      ext_irq_port_select_high_reg <= ext_irq_port_select_high_next;
    end
  end

  // ******************************************************************
  // Register reads
  // ******************************************************************
  // Zero unless a mapped register is read, so stale data never linger
  always @* begin
    reg_rdata_next = 32'h0000_0000;
    if (reg_read && low_hit) begin
      reg_rdata_next = ext_irq_port_select_low_reg;
    end else if (reg_read && high_hit) begin
      reg_rdata_next = ext_irq_port_select_high_reg;
    end
  end

  // Read data stand one cycle after the strobe
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rdata_next;
    end
  end

  // ******************************************************************
  // Pin synchronisers
  // ******************************************************************
  // Pins are asynchronous; two stages before the muxes look at them
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pins_meta_reg <= 96'h0;
      pins_sync_reg <= 96'h0;
    end else begin
      pins_meta_reg <= {bank_f_pins, bank_e_pins, bank_d_pins,
                        bank_c_pins, bank_b_pins, bank_a_pins};
      pins_sync_reg <= pins_meta_reg;
    end
  end

  // Second stage only, split back into its six banks
  assign bank_a_sync = pins_sync_reg[15:0];
  assign bank_b_sync = pins_sync_reg[31:16];
  assign bank_c_sync = pins_sync_reg[47:32];
  assign bank_d_sync = pins_sync_reg[63:48];
  assign bank_e_sync = pins_sync_reg[79:64];
  assign bank_f_sync = pins_sync_reg[95:80];

  // ******************************************************************
  // Selector fields
  // ******************************************************************
  // Lines 0 to 7 read the low word, 8 to 15 the high word
  // R3 line 0 field
  assign line0_source_port = line_source_port(ext_irq_port_select_low_reg,
    ext_irq_port_select_high_reg, 4'd0);
  // R4 lines 1 to 3
  assign line1_source_port = line_source_port(ext_irq_port_select_low_reg,
    ext_irq_port_select_high_reg, 4'd1);
  assign line2_source_port = line_source_port(ext_irq_port_select_low_reg,
    ext_irq_port_select_high_reg, 4'd2);
  assign line3_source_port = line_source_port(ext_irq_port_select_low_reg,
    ext_irq_port_select_high_reg, 4'd3);
  assign line4_source_port = line_source_port(ext_irq_port_select_low_reg,
    ext_irq_port_select_high_reg, 4'd4);
  assign line5_source_port = line_source_port(ext_irq_port_select_low_reg,
    ext_irq_port_select_high_reg, 4'd5);
  assign line6_source_port = line_source_port(ext_irq_port_select_low_reg,
    ext_irq_port_select_high_reg, 4'd6);
  assign line7_source_port = line_source_port(ext_irq_port_select_low_reg,
    ext_irq_port_select_high_reg, 4'd7);
  // R6 lines 8 to 15
  assign line8_source_port = line_source_port(ext_irq_port_select_low_reg,
    ext_irq_port_select_high_reg, 4'd8);
  assign line9_source_port = line_source_port(ext_irq_port_select_low_reg,
    ext_irq_port_select_high_reg, 4'd9);
  assign line10_source_port = line_source_port(ext_irq_port_select_low_reg,
    ext_irq_port_select_high_reg, 4'd10);
  assign line11_source_port = line_source_port(ext_irq_port_select_low_reg,
    ext_irq_port_select_high_reg, 4'd11);
  assign line12_source_port = line_source_port(ext_irq_port_select_low_reg,
    ext_irq_port_select_high_reg, 4'd12);
  assign line13_source_port = line_source_port(ext_irq_port_select_low_reg,
    ext_irq_port_select_high_reg, 4'd13);
  assign line14_source_port = line_source_port(ext_irq_port_select_low_reg,
    ext_irq_port_select_high_reg, 4'd14);
  assign line15_source_port = line_source_port(ext_irq_port_select_low_reg,
    ext_irq_port_select_high_reg, 4'd15);

  // Packed for the generate loop, line 0 in the low bits
  assign line_ports = {line15_source_port, line14_source_port,
    line13_source_port, line12_source_port, line11_source_port,
    line10_source_port, line9_source_port, line8_source_port,
    line7_source_port, line6_source_port, line5_source_port,
    line4_source_port, line3_source_port, line2_source_port,
    line1_source_port, line0_source_port};

  // ******************************************************************
  // Line routing
  // ******************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_line
      // R2 pin n only
      eips_line_mux u_mux (
        .source_port(line_ports[gi*`EIPS_FIELD_W +: `EIPS_FIELD_W]),
        .bank_pins({bank_f_sync[gi], bank_e_sync[gi], bank_d_sync[gi],
                    bank_c_sync[gi], bank_b_sync[gi], bank_a_sync[gi]}),
        .line_out(line_next[gi])
      );
    end
  endgenerate

  // Registered so every output comes from a flip-flop
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ext_irq_lines <= 16'h0000;
    end else begin
      ext_irq_lines <= line_next;
    end
  end

endmodule

`default_nettype wire

// ==== dv/eips_top_asserts.sv ====
`default_nettype none
module eips_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic [15:0] ext_irq_lines
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_rsv; (reg_rdata & 32'h8888_8888) == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit read");
  property p_lo; reg_write && reg_addr == 12'h100 ##1 reg_read &&
    reg_addr == 12'h100 |=> reg_rdata == ($past(reg_wdata, 2) & 32'h7777_7777);
  endproperty
  a_lo: assert property (p_lo) else $error("low readback");
  property p_hi; reg_write && reg_addr == 12'h104 ##1 reg_read &&
    reg_addr == 12'h104 |=> reg_rdata == ($past(reg_wdata, 2) & 32'h7777_7777);
  endproperty
  a_hi: assert property (p_hi) else $error("high readback");
  property p_map; reg_read && !(reg_addr inside {12'h100, 12'h104})
    |=> reg_rdata == 32'h0; endproperty
  a_map: assert property (p_map) else $error("unmapped read");
  property p_sev; reg_write && reg_addr == 12'h100 &&
    reg_wdata == 32'h7777_7777 |-> ##2 ext_irq_lines[7:0] == 8'h0; endproperty
  a_sev: assert property (p_sev) else $error("code 7 line");
  property p_six; reg_write && reg_addr == 12'h104 &&
    reg_wdata == 32'h6666_6666 |-> ##2 ext_irq_lines[15:8] == 8'h0; endproperty
  a_six: assert property (p_six) else $error("code 6 line");
endmodule
bind eips_top eips_checker u_chk (.clk(clk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .ext_irq_lines(ext_irq_lines));
`default_nettype wire

// ==== dv/tb_ext_irq_port_select.sv ====
`default_nettype none
module tb_ext_irq_port_select;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, resetn = 0, reg_write = 0, reg_read = 0;
  logic [11:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, lo, hi, v, seed = 32'h67cd89df;
  logic [15:0] b [6] = '{default: 0};
  logic [15:0] ext_irq_lines;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  eips_top dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .bank_a_pins(b[0]), .bank_b_pins(b[1]),
    .bank_c_pins(b[2]), .bank_d_pins(b[3]), .bank_e_pins(b[4]),
    .bank_f_pins(b[5]), .ext_irq_lines(ext_irq_lines));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Callers enter just after an edge, so strobes can run back to back
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    // Data launched at the strobe edge are read at the next edge
    @(posedge clk);
    chk(reg_rdata, e);
  endtask
  // Pins need three edges to reach the lines, so wait four
  task automatic lines();
    logic [15:0] e;
    logic [31:0] s;
    for (int k = 0; k < 6; k++) b[k] <= 16'(rnd());
    repeat (4) @(posedge clk);
    for (int n = 0; n < 16; n++) begin
      s = (n < 8 ? lo : hi) >> (4 * (n % 8));
      e[n] = s[2:0] < 6 ? b[s[2:0]][n] : 1'b0;
    end
    chk(ext_irq_lines, e);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    forever #2 clk = ~clk;
  end
  // Ceiling well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(12'h100, 0);
    rd(12'h104, 0);
    // First eight passes set every code in every field
    for (int i = 0; i < 24; i++) begin
      v = i * 32'h1111_1111;
      lo = i < 8 ? v : rnd() & 32'h7777_7777;
      hi = i < 8 ? v : rnd() & 32'h7777_7777;
      wr(12'h100, lo);
      rd(12'h100, lo);
      wr(12'h104, hi);
      rd(12'h104, hi);
      lines();
      $display("test %0d done", i);
    end
    // Every low-register field bit is written as one and read back; reserved bits are left zero in the write data
    wr(12'h100, 32'h7777_7777);
    rd(12'h100, 32'h7777_7777);
    wr(12'h108, 32'h1);
    rd(12'h108, 0);
    // An unmapped write must leave both selectors alone
    rd(12'h100, 32'h7777_7777);
    rd(12'h104, hi);
    $display("test map done");
    // Mid-run reset returns every line to port A
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(12'h100, 0);
    rd(12'h104, 0);
    lo = 0;
    hi = 0;
    lines();
    $display("test reset done");
    stop_test();
  end
endmodule
`default_nettype wire
